// ---- fhp_cfg.svh ----
`ifndef FHP_CFG_SVH
`define FHP_CFG_SVH

// Status byte layout
`define FHP_ST_READY 7
`define FHP_ST_DIR 6
`define FHP_ST_PIO 5
`define FHP_ST_BUSY 4
`define FHP_ST_SEEK_LO 0
`define FHP_DRIVES 4

// Byte written to the cancel trigger that starts a software abort
`define FHP_ABORT_CODE 8'hFF

// Data path buffering
`define FHP_DATA_W 8
`define FHP_FIFO_DEPTH 16

// Synchroniser: 16 pin bits, idle levels after reset
`define FHP_SYNC_W 16
`define FHP_SYNC_RST 16'h3B00
`define FHP_PIN_STYLE 15
`define FHP_PIN_CLASS 14
`define FHP_PIN_STB_A 13
`define FHP_PIN_STB_B 12
`define FHP_PIN_CS 11
`define FHP_PIN_RS 10
`define FHP_PIN_GRANT 9
`define FHP_PIN_STOP 8

`endif

// ---- fhp_pkg.sv ----
package fhp_pkg;
    typedef enum {ACC_IDLE, ACC_READ, ACC_WRITE} fhp_acc_type;

    // Controller state reported by the command engine
    typedef struct packed {
        logic dir_to_host;
        logic pio_exec;
        logic busy;
        logic pio_mode;
        logic dma_active;
    } fhp_core_stat_type;

    // Events sent back to the command engine
    typedef struct packed {
        logic abort;
        logic dma_end;
        logic rate_high;
    } fhp_core_evt_type;
endpackage

// ---- fhp_host_port.sv ----
// What this block does
// - Reset drives request, interrupt and res_ready high, others low, data bus input.
// - Strap 0 gives separate read/write strobes; 1 gives enable plus direction.
// - Select low: read status, write cancel trigger; high: data port.
// - Without chip select or grant, strobes ignored and bus undriven.
// - Enable style: direction sense under grant is opposite to chip select.
// - Grant-qualified accesses ignore register select and use the data port.
// - Separate style: low read strobe outputs data, low write strobe inputs.
// - Interrupt pin is open drain with strap high, push-pull with strap low.
// - Interrupt asks for programmed transfers and flags command completion.
// - Request line asks each DMA byte; grant answers; stop input ends DMA.
// - Status bit 7 shows data port ready, clears when a data port access begins.
// - Status bit 6 gives data direction, 1 means host reads.
// - Status bit 5 set only during programmed-transfer read/write commands.
// - Status bit 4 shows busy; host waits for 0 except abort.
// - Status bits 0-3 set on seek per drive, clear when end accepted.
// - Writing FF to cancel trigger aborts in any state; other values ignored.
// - Data port is a byte stack with one entry on the bus.
// - Drive-class strap selects the slow or fast serial rate family.
`include "fhp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module fhp_fifo #(
    parameter int WIDTH = `FHP_DATA_W,
    parameter int DEPTH = `FHP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
    // Storage has no reset so it maps to plain RAM
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule

module fhp_host_port (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Straps
    input wire logic bus_style_strap,
    input wire logic drive_class_strap,
    // Host bus strobes and selects
    input wire logic strobe_a_n,
    input wire logic strobe_b_n,
    input wire logic chip_select_n,
    input wire logic register_select,
    // Host data bus, three signals
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Interrupt pin, two signals
    output logic irq_out,
    output logic irq_oe_n,
    // DMA handshake
    output logic transfer_request_out_n,
    input wire logic transfer_grant_in_n,
    input wire logic transfer_stop_in_n,
    // Command engine status and events
    input wire fhp_pkg::fhp_core_stat_type core_stat,
    input wire logic [3:0] seek_start,
    input wire logic [3:0] seek_accept,
    input wire logic cmd_done,
    input wire logic done_clear,
    output fhp_pkg::fhp_core_evt_type core_evt,
    // Bytes written by the host toward the engine
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [7:0] cmd_data,
    // Bytes from the engine toward the host
    input wire logic res_valid,
    output logic res_ready,
    input wire logic [7:0] res_data
);
    import fhp_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [`FHP_SYNC_W-1:0] pins, s1_q, s2_q, s3_q, flt_q, flt_d;
    assign pins = {bus_style_strap, drive_class_strap, strobe_a_n, strobe_b_n, chip_select_n,
                   register_select, transfer_grant_in_n, transfer_stop_in_n, data_in};
    // A change counts only when stages two and three agree
    generate
        for (genvar i = 0; i < `FHP_SYNC_W; i++) begin : g_flt
            always_comb begin
                flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
            end
        end
    endgenerate
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= `FHP_SYNC_RST;
            s2_q <= `FHP_SYNC_RST;
            s3_q <= `FHP_SYNC_RST;
            flt_q <= `FHP_SYNC_RST;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end
    // ****************************************
    // Access decode
    // ****************************************
    logic style, cs, grant, rd_raw, wr_raw, rd_act, wr_act, to_data;
    assign style = flt_q[`FHP_PIN_STYLE];
    assign cs = !flt_q[`FHP_PIN_CS];
    assign grant = !flt_q[`FHP_PIN_GRANT];
    always_comb begin
        if (style) begin
            rd_raw = flt_q[`FHP_PIN_STB_A] && (grant ? !flt_q[`FHP_PIN_STB_B] : flt_q[`FHP_PIN_STB_B]);
            wr_raw = flt_q[`FHP_PIN_STB_A] && (grant ? flt_q[`FHP_PIN_STB_B] : !flt_q[`FHP_PIN_STB_B]);
        end else begin
            rd_raw = !flt_q[`FHP_PIN_STB_A] && flt_q[`FHP_PIN_STB_B];
            wr_raw = !flt_q[`FHP_PIN_STB_B] && flt_q[`FHP_PIN_STB_A];
        end
    end

    assign rd_act = (cs || grant) && rd_raw;
    assign wr_act = (cs || grant) && wr_raw;
    // grant always routes to data port
    assign to_data = grant || flt_q[`FHP_PIN_RS];
    // ****************************************
    // Data stack
    // ****************************************
    // byte stack, head entry on the bus
    logic rx_valid, rx_pop, tx_ready, tx_push;
    logic [7:0] rx_head, wbyte_q, wbyte_d;
    fhp_fifo #(.WIDTH(`FHP_DATA_W), .DEPTH(`FHP_FIFO_DEPTH)) u_to_host (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data(res_data),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_head)
    );
    fhp_fifo #(.WIDTH(`FHP_DATA_W), .DEPTH(`FHP_FIFO_DEPTH)) u_to_core (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(tx_push),
        .in_ready(tx_ready),
        .in_data(wbyte_q),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd_data)
    );

    // ****************************************
    // Access sequencer and status
    // ****************************************
    fhp_acc_type acc_q, acc_d;
    logic sel_q, sel_d, oe_n_q, oe_n_d, ready_q, ready_d, rdy_cond, start_data;
    logic abort_q, abort_d, stop_prev_q, stop_seen_q, stop_seen_d, transfer_stop_in_q, transfer_stop_in_d;
    logic done_q, done_d, req_n_q, req_n_d, irq_q, irq_d, irq_oe_n_q, irq_oe_n_d;
    logic [3:0] seek_q, seek_d;
    logic [7:0] dout_q, dout_d, status;

    assign rdy_cond = core_stat.dir_to_host ? rx_valid : tx_ready;
    assign start_data = (acc_q == ACC_IDLE) && (rd_act || wr_act) && to_data;
    assign status = {ready_q, core_stat.dir_to_host, core_stat.pio_exec, core_stat.busy, seek_q};

    always_comb begin
        acc_d = acc_q;
        sel_d = sel_q;
        oe_n_d = oe_n_q;
        dout_d = dout_q;
        wbyte_d = flt_q[7:0];
        rx_pop = 1'b0;
        tx_push = 1'b0;
        abort_d = 1'b0;
        case (acc_q)
            ACC_IDLE: begin
                sel_d = to_data;
                if (rd_act) begin
                    acc_d = ACC_READ;
                    oe_n_d = 1'b0;
                    dout_d = to_data ? rx_head : status;
                    rx_pop = to_data;
                end else if (wr_act) begin
                    acc_d = ACC_WRITE;
                end
            end
            ACC_READ: begin
                if (!rd_act) begin
                    acc_d = ACC_IDLE;
                    oe_n_d = 1'b1;
                end
            end
            ACC_WRITE: begin
                // Byte is taken from the last cycle the strobe was still active
                if (!wr_act) begin
                    acc_d = ACC_IDLE;
                    wbyte_d = wbyte_q;
                    tx_push = sel_q;
                    abort_d = !sel_q && (wbyte_q == `FHP_ABORT_CODE);
                end
            end
            default: begin
                acc_d = ACC_IDLE;
                oe_n_d = 1'b1;
            end
        endcase

        if (start_data) begin
            ready_d = 1'b0;
        end else if (acc_q == ACC_IDLE) begin
            ready_d = rdy_cond;
        end else begin
            ready_d = ready_q;
        end

        // seek bits, set wins over accept
        seek_d = (seek_q & ~seek_accept) | seek_start;
        done_d = (done_q && !done_clear) || cmd_done;

        // stop edge ends the DMA run until the engine drops it
        transfer_stop_in_d = stop_prev_q && !flt_q[`FHP_PIN_STOP] && core_stat.dma_active;
        stop_seen_d = transfer_stop_in_d || (stop_seen_q && core_stat.dma_active);
        // one request per byte, dropped once granted
        req_n_d = !(core_stat.dma_active && !stop_seen_d && !transfer_stop_in_d && ready_d && !grant
                    && (acc_q == ACC_IDLE));

        irq_d = (core_stat.pio_mode && core_stat.pio_exec && ready_d) || done_d;
        // open drain only when the strap is high
        irq_oe_n_d = style ? !irq_d : 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= ACC_IDLE;
            sel_q <= 1'b0;
            oe_n_q <= 1'b1;
            dout_q <= 8'h00;
            wbyte_q <= 8'h00;
            ready_q <= 1'b0;
            abort_q <= 1'b0;
            seek_q <= 4'h0;
            done_q <= 1'b0;
            stop_prev_q <= 1'b1;
            stop_seen_q <= 1'b0;
            transfer_stop_in_q <= 1'b0;
            req_n_q <= 1'b1;
            irq_q <= 1'b0;
            irq_oe_n_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            sel_q <= sel_d;
            oe_n_q <= oe_n_d;
            dout_q <= dout_d;
            wbyte_q <= wbyte_d;
            ready_q <= ready_d;
            abort_q <= abort_d;
            seek_q <= seek_d;
            done_q <= done_d;
            stop_prev_q <= flt_q[`FHP_PIN_STOP];
            stop_seen_q <= stop_seen_d;
            transfer_stop_in_q <= transfer_stop_in_d;
            req_n_q <= req_n_d;
            irq_q <= irq_d;
            irq_oe_n_q <= irq_oe_n_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign data_out = dout_q;
    assign data_oe_n = oe_n_q;
    assign irq_out = !irq_q;
    assign irq_oe_n = irq_oe_n_q;
    assign transfer_request_out_n = req_n_q;
    assign core_evt.abort = abort_q;
    assign core_evt.dma_end = transfer_stop_in_q;
    // rate family from the drive-class strap
    assign core_evt.rate_high = flt_q[`FHP_PIN_CLASS];
endmodule

`default_nettype wire

// ---- fhp_host_port_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module fhp_host_port_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Pins watched
    input wire logic bus_style_strap,
    input wire logic drive_class_strap,
    input wire logic chip_select_n,
    input wire logic data_oe_n,
    input wire logic irq_out,
    input wire logic irq_oe_n,
    input wire logic transfer_request_out_n,
    input wire logic transfer_grant_in_n,
    input wire logic transfer_stop_in_n,
    // Engine side
    input wire fhp_pkg::fhp_core_evt_type core_evt,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_data
);
    // ************************
    // Port properties
    // ************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_rst; $rose(nrst) |-> data_oe_n && irq_out && !irq_oe_n && transfer_request_out_n; endproperty
    property p_oe; $fell(data_oe_n) |-> !$past(chip_select_n, 4) || !$past(transfer_grant_in_n, 4); endproperty
    property p_nosel; (chip_select_n && transfer_grant_in_n) [*8] |-> data_oe_n; endproperty
    property p_od; bus_style_strap && $past(bus_style_strap, 5) && irq_out |-> irq_oe_n; endproperty
    property p_pp; !bus_style_strap && !$past(bus_style_strap, 5) |-> !irq_oe_n; endproperty
    property p_abort; core_evt.abort |=> !core_evt.abort; endproperty
    property p_end; core_evt.dma_end |-> !$past(transfer_stop_in_n, 4) ##1 !core_evt.dma_end; endproperty
    property p_grant; !transfer_grant_in_n [*7] |-> transfer_request_out_n; endproperty
    property p_rate; drive_class_strap [*6] |-> core_evt.rate_high; endproperty
    property p_cmd; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data); endproperty
    a_rst: assert property (p_rst) else $error("bad reset levels");
    a_oe: assert property (p_oe) else $error("bus driven unselected");
    a_nosel: assert property (p_nosel) else $error("bus left driven");
    a_od: assert property (p_od) else $error("irq not open drain");
    a_pp: assert property (p_pp) else $error("irq not push-pull");
    a_abort: assert property (p_abort) else $error("abort pulse long");
    a_end: assert property (p_end) else $error("stray dma end");
    a_grant: assert property (p_grant) else $error("request kept under grant");
    a_rate: assert property (p_rate) else $error("rate not followed");
    a_cmd: assert property (p_cmd) else $error("byte dropped");
    c_abort: cover property (core_evt.abort);
    c_end: cover property (core_evt.dma_end);
    c_read: cover property ($fell(data_oe_n));
endmodule
bind fhp_host_port fhp_host_port_props i_props (.sys_clk(sys_clk), .nrst(nrst), .bus_style_strap(bus_style_strap),
    .drive_class_strap(drive_class_strap), .chip_select_n(chip_select_n), .data_oe_n(data_oe_n),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .transfer_request_out_n(transfer_request_out_n),
    .transfer_grant_in_n(transfer_grant_in_n), .transfer_stop_in_n(transfer_stop_in_n),
    .core_evt(core_evt), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data));
`default_nettype wire

// ---- fhp_engine_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fhp_engine_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Stall control
    input wire logic stall,
    // Bytes from the port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_data,
    // Bytes toward the port
    output logic res_valid,
    input wire logic res_ready,
    output logic [7:0] res_data
);
    // ************************
    // Engine byte streams
    // ************************
    logic [7:0] got[$];
    logic [7:0] tx[$];
    assign cmd_ready = !stall;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            res_valid <= 1'b0;
            res_data <= 8'h00;
        end else begin
            if (cmd_valid && cmd_ready) got.push_back(cmd_data);
            if (res_valid && res_ready) tx.delete(0);
            res_valid <= tx.size() > 0;
            // Idle data toggles so a stale byte never looks valid
            res_data <= (tx.size() > 0) ? tx[0] : ~res_data;
        end
    end
endmodule
`default_nettype wire

// ---- fhp_host_port_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module fhp_host_port_test;
    import fhp_pkg::*;
    // ************************
    // Bench
    // ************************
    logic clk = 0, nrst = 0, sty = 0, cls = 0, a_n = 1, b_n = 1, cs_n = 1, rs = 0;
    logic gnt_n = 1, stp_n = 1, done = 0, dclr = 0, stall = 0;
    logic [7:0] din = 8'h00, q, dout, cmd_d, res_d;
    logic [3:0] sk_s = 4'h0, sk_a = 4'h0;
    fhp_core_stat_type st = '0;
    fhp_core_evt_type evt;
    logic oe_n, irq, irq_oe, rq_n, cmd_v, cmd_r, res_v, res_r;
    int fail_count = 0, tests_run = 0, cyc = 0, n_ab = 0, n_end = 0;
    always #5 clk = ~clk;
    fhp_host_port i_dut (.sys_clk(clk), .nrst(nrst), .bus_style_strap(sty), .drive_class_strap(cls),
        .strobe_a_n(a_n), .strobe_b_n(b_n), .chip_select_n(cs_n), .register_select(rs), .data_in(din),
        .data_out(dout), .data_oe_n(oe_n), .irq_out(irq), .irq_oe_n(irq_oe), .transfer_request_out_n(rq_n),
        .transfer_grant_in_n(gnt_n), .transfer_stop_in_n(stp_n), .core_stat(st), .seek_start(sk_s),
        .seek_accept(sk_a), .cmd_done(done), .done_clear(dclr), .core_evt(evt), .cmd_valid(cmd_v),
        .cmd_ready(cmd_r), .cmd_data(cmd_d), .res_valid(res_v), .res_ready(res_r), .res_data(res_d));
    fhp_engine_model i_eng (.sys_clk(clk), .nrst(nrst), .stall(stall), .cmd_valid(cmd_v), .cmd_ready(cmd_r),
        .cmd_data(cmd_d), .res_valid(res_v), .res_ready(res_r), .res_data(res_d));
    always @(posedge clk) begin
        cyc++;
        if (evt.abort === 1'b1) n_ab++;
        if (evt.dma_end === 1'b1) n_end++;
        if (cyc == 30000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One bus cycle, qualified by grant when g is set, read when r is set
    task automatic acc(input logic g, input logic r, input logic s, input logic [7:0] d, output logic [7:0] v);
        v = 8'h00;
        @(negedge clk);
        cs_n = g;
        gnt_n = !g;
        rs = s;
        din = d;
        a_n = sty ? 1'b1 : !r;
        b_n = sty ? (g ? !r : r) : r;
        repeat (8) begin
            @(negedge clk);
            if (oe_n === 1'b0) v = dout;
        end
        a_n = !sty;
        b_n = 1;
        cs_n = 1;
        gnt_n = 1;
        idle(8);
    endtask
    task automatic t_reset();
        repeat (3) @(posedge clk);
        #1;
        chk({oe_n, irq, rq_n, irq_oe, cmd_v, res_r}, 8'h39);
        chk(dout, 8'h00);
        @(negedge clk) nrst = 1;
        cls = 1;
        idle(8);
        chk(evt.rate_high, 1'b1);
    endtask
    task automatic t_status();
        st = 5'b01100;
        sk_s = 4'h4;
        @(negedge clk) sk_s = 4'h0;
        acc(0, 1, 0, 8'h00, q);
        chk(q, 8'hB4);
        sk_a = 4'h4;
        @(negedge clk) sk_a = 4'h0;
        st = '0;
        acc(0, 1, 0, 8'h00, q);
        chk(q, 8'h80);
        acc(0, 0, 0, 8'h7E, q);
        chk(8'(n_ab), 8'h00);
        acc(0, 0, 0, 8'hFF, q);
        chk(8'(n_ab), 8'h01);
    endtask
    task automatic t_nosel();
        a_n = 0;
        idle(10);
        chk(oe_n, 1'b1);
        a_n = 1;
        b_n = 0;
        din = 8'hFF;
        idle(10);
        b_n = 1;
        idle(10);
        chk(8'(n_ab), 8'h01);
    endtask
    task automatic t_fifo();
        stall = 1;
        for (int i = 0; i < 17; i++) acc(0, 0, 1, 8'h10 + 8'(i), q);
        acc(0, 1, 0, 8'h00, q);
        chk(q, 8'h00);
        stall = 0;
        idle(20);
        chk(8'(i_eng.got.size()), 8'h10);
        foreach (i_eng.got[i]) chk(i_eng.got[i], 8'h10 + 8'(i));
        i_eng.got.delete();
        st = 5'b10000;
        for (int i = 0; i < 3; i++) i_eng.tx.push_back(8'hA0 + 8'(i));
        idle(8);
        acc(0, 1, 0, 8'h00, q);
        chk(q, 8'hC0);
        for (int i = 0; i < 3; i++) begin
            acc(0, 1, 1, 8'h00, q);
            chk(q, 8'hA0 + 8'(i));
        end
        acc(0, 1, 0, 8'h00, q);
        chk(q, 8'h40);
    endtask
    task automatic t_dma();
        i_eng.tx.push_back(8'h5A);
        st = 5'b10001;
        idle(10);
        chk(rq_n, 1'b0);
        acc(1, 1, 0, 8'h00, q);
        chk(q, 8'h5A);
        stp_n = 0;
        idle(10);
        stp_n = 1;
        i_eng.tx.push_back(8'h5B);
        idle(10);
        chk({rq_n, 7'(n_end)}, 8'h81);
        st = '0;
    endtask
    task automatic t_irq();
        done = 1;
        @(negedge clk) done = 0;
        idle(3);
        chk({irq, irq_oe}, 8'h00);
        dclr = 1;
        @(negedge clk) dclr = 0;
        idle(3);
        chk({irq, irq_oe}, 8'h02);
        st = 5'b01010;
        idle(3);
        chk(irq, 1'b0);
        st = '0;
        idle(3);
    endtask
    task automatic t_style();
        sty = 1;
        a_n = 0;
        idle(8);
        chk(irq_oe, 1'b1);
        acc(0, 1, 0, 8'h00, q);
        chk(q, 8'h80);
        acc(0, 0, 0, 8'hFF, q);
        chk(8'(n_ab), 8'h02);
        st = 5'b00001;
        acc(1, 0, 0, 8'h77, q);
        idle(4);
        chk(i_eng.got[0], 8'h77);
        st = 5'b10001;
        idle(8);
        acc(1, 1, 0, 8'h00, q);
        chk(q, 8'h5B);
    endtask
    initial begin
        t_reset();
        t_status();
        t_nosel();
        t_fifo();
        t_dma();
        t_irq();
        t_style();
        close_out();
    end
endmodule
`default_nettype wire
